// File: hw/module_flag_interrupt_latency.sv
// Flag latching, interrupt, output disable and auto squelch logic.
// Assumes a Wishbone master on clk_sys and raw link and line pins.
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
module module_flag_interrupt_latency #(
  parameter int unsigned LANES     = 4,
  parameter int unsigned MS_CYCLES = module_flag_pkg::MS_CYCLES,
  parameter int unsigned TX_ON_MS  = module_flag_pkg::TX_ON_MS
) (
  input  wire logic                                 clk_sys,      // System clock
  input  wire logic                                 resetn,       // Async reset, low
  input  wire logic                                 wb_cyc_i,     // Bus cycle
  input  wire logic                                 wb_stb_i,     // Bus strobe
  input  wire logic                                 wb_we_i,      // Write enable
  input  wire logic [module_flag_pkg::ADR_W-1:0]    wb_adr_i,     // Byte address
  input  wire logic [3:0]                           wb_sel_i,     // Byte enables
  input  wire logic [31:0]                          wb_dat_i,     // Write data
  output logic      [31:0]                          wb_dat_o,     // Read data
  output logic                                      wb_ack_o,     // Acknowledge
  input  wire logic                                 scl_in,       // Link clock pin
  input  wire logic                                 sda_in,       // Link data pin
  input  wire logic [LANES-1:0]                     rx_los_in,    // Rx loss per lane
  input  wire logic [LANES-1:0]                     tx_fault_in,  // Tx failure per lane
  input  wire logic [LANES-1:0]                     tx_los_in,    // Tx input loss
  output logic                                      irq_o,        // Interrupt, high
  output logic      [LANES-1:0]                     tx_disable_o, // Tx lane off
  output logic      [LANES-1:0]                     rx_squelch_o, // Rx output off
  output logic      [LANES-1:0]                     tx_squelch_o  // Tx squelched
);
  import module_flag_pkg::*;

  localparam int unsigned TW = $clog2(MS_CYCLES + 1);
  localparam logic [31:0] LANE_ONES = 32'((64'h1 << LANES) - 64'h1);
  localparam logic [31:0] FLAG_USED = (LANE_ONES << FLAG_RXLOS_LSB)
                                    | (LANE_ONES << FLAG_TXF_LSB)
                                    | (LANE_ONES << FLAG_TXLOS_LSB);
  localparam logic [31:0] CTRL_USED = (LANE_ONES << CTRL_TXOFF_LSB)
                                    | (LANE_ONES << CTRL_RXOFF_LSB)
                                    | (32'h1 << CTRL_SQDIS_BIT);

  typedef struct packed {
    logic [1:0]       scl_sy;
    logic [1:0]       sda_sy;
    logic             sda_prev;
    logic [LANES-1:0] rxl_s1;
    logic [LANES-1:0] rxl_s2;
    logic [LANES-1:0] rxl_d;
    logic [LANES-1:0] txf_s1;
    logic [LANES-1:0] txf_s2;
    logic [LANES-1:0] txf_d;
    logic [LANES-1:0] txl_s1;
    logic [LANES-1:0] txl_s2;
    logic [LANES-1:0] txl_d;
    logic [31:0]      flag;
    logic [31:0]      mask;
    logic [31:0]      ctrl;
    logic [LANES-1:0] tx_off;
    logic [LANES-1:0] rx_off;
    logic             sq_dis;
    logic [LANES-1:0] tx_dis;
    logic [LANES-1:0] rx_sq;
    logic [LANES-1:0] tx_sq;
    logic [TW-1:0]    tick_cnt;
    logic [7:0]       on_wait;
    logic             ack;
    logic [31:0]      dat;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic             take;
  logic             stop_det;
  logic             tick;
  logic [31:0]      set_v;
  logic [31:0]      clr_v;
  logic [31:0]      be_mask;
  logic [31:0]      rd_data;
  logic [LANES-1:0] new_tx_off;

  // Byte enables widened to a bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
    end
  end

  assign take     = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  // STOP: data rises while clock is high, both taken after the synchroniser
  assign stop_det = st_reg.scl_sy[1] & st_reg.sda_sy[1] & ~st_reg.sda_prev;
  assign tick     = (st_reg.tick_cnt == TW'(MS_CYCLES - 1));
  assign new_tx_off = st_reg.ctrl[CTRL_TXOFF_LSB +: LANES];

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      ADDR_FLAG:  rd_data = st_reg.flag;
      ADDR_MASK:  rd_data = st_reg.mask;
      ADDR_CTRL:  rd_data = st_reg.ctrl;
      ADDR_STATE: begin
        rd_data[CTRL_TXOFF_LSB +: LANES]  = st_reg.tx_off;
        rd_data[CTRL_RXOFF_LSB +: LANES]  = st_reg.rx_off;
        rd_data[CTRL_SQDIS_BIT]           = st_reg.sq_dis;
        rd_data[STATE_TXDIS_LSB +: LANES] = st_reg.tx_dis;
      end
      ADDR_DUR: begin
        rd_data[DUR_OFF_LSB +: 8] = ADV_TX_OFF_MS;
        rd_data[DUR_ON_LSB +: 8]  = ADV_TX_ON_MS;
      end
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    // Two-stage synchronisers; only stage two feeds logic
    st_next.scl_sy   = {st_reg.scl_sy[0], scl_in};
    st_next.sda_sy   = {st_reg.sda_sy[0], sda_in};
    st_next.sda_prev = st_reg.sda_sy[1];
    st_next.rxl_s1   = rx_los_in;
    st_next.rxl_s2   = st_reg.rxl_s1;
    st_next.rxl_d    = st_reg.rxl_s2;
    st_next.txf_s1   = tx_fault_in;
    st_next.txf_s2   = st_reg.txf_s1;
    st_next.txf_d    = st_reg.txf_s2;
    st_next.txl_s1   = tx_los_in;
    st_next.txl_s2   = st_reg.txl_s1;
    st_next.txl_d    = st_reg.txl_s2;

    // Onsets latch flags; a held condition does not re-flag after a read
    set_v = 32'h0000_0000;
    set_v[FLAG_RXLOS_LSB +: LANES] = st_reg.rxl_s2 & ~st_reg.rxl_d;
    set_v[FLAG_TXF_LSB +: LANES]   = st_reg.txf_s2 & ~st_reg.txf_d;
    set_v[FLAG_TXLOS_LSB +: LANES] = st_reg.txl_s2 & ~st_reg.txl_d;

    // Clear on read and write-one-to-clear; a new onset wins over the clear
    clr_v = 32'h0000_0000;
    if (take && (wb_adr_i == ADDR_FLAG)) begin
      clr_v = wb_we_i ? (wb_dat_i & be_mask) : st_reg.flag;
    end
    st_next.flag = ((st_reg.flag & ~clr_v) | set_v) & FLAG_USED;

    if (take && wb_we_i && (wb_adr_i == ADDR_MASK)) begin
      st_next.mask = ((st_reg.mask & ~be_mask) | (wb_dat_i & be_mask)) & FLAG_USED;
    end
    // Control writes wait here until the link transaction ends
    if (take && wb_we_i && (wb_adr_i == ADDR_CTRL)) begin
      st_next.ctrl = ((st_reg.ctrl & ~be_mask) | (wb_dat_i & be_mask)) & CTRL_USED;
    end

    // Millisecond tick, free running
    st_next.tick_cnt = tick ? '0 : TW'(st_reg.tick_cnt + 1'b1);
    if (tick && (st_reg.on_wait != 8'h00)) begin
      st_next.on_wait = 8'(st_reg.on_wait - 8'h01);
    end

    if (stop_det) begin
      st_next.tx_off = new_tx_off;
      st_next.rx_off = st_reg.ctrl[CTRL_RXOFF_LSB +: LANES];
      st_next.sq_dis = st_reg.ctrl[CTRL_SQDIS_BIT];
      // A lane being re-enabled restarts the settle wait
      if ((st_reg.tx_off & ~new_tx_off) != '0) begin
        st_next.on_wait = 8'(TX_ON_MS);
      end
    end

    // Turn-off is immediate; turn-on holds until the settle wait expires
    st_next.tx_dis = st_next.tx_off
                   | ((st_next.on_wait != 8'h00) ? st_reg.tx_dis : '0);
    st_next.rx_sq  = st_next.rx_off
                   | ({LANES{~st_next.sq_dis}} & st_reg.rxl_s2);
    st_next.tx_sq  = {LANES{~st_next.sq_dis}} & st_reg.txl_s2;

    // Single-wait-state slave; unmapped reads give zero
    st_next.ack = take;
    st_next.dat = (take && !wb_we_i) ? rd_data : 32'h0000_0000;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg          <= '0;
      // Link pins idle high; a zero start would fake a STOP at release
      st_reg.scl_sy   <= 2'h3;
      st_reg.sda_sy   <= 2'h3;
      st_reg.sda_prev <= 1'b1;
      st_reg.mask <= MASK_RST;
      st_reg.ctrl <= CTRL_RST;
    end else begin
      st_reg      <= st_next;
    end
  end

  // Mask bit high keeps its flag off the line
  assign irq_o        = |(st_reg.flag & ~st_reg.mask);
  assign tx_disable_o = st_reg.tx_dis;
  assign rx_squelch_o = st_reg.rx_sq;
  assign tx_squelch_o = st_reg.tx_sq;
  assign wb_ack_o     = st_reg.ack;
  assign wb_dat_o     = st_reg.dat;

  // Helper logic read only by the checks below
  localparam int REL_MAX = (TX_ON_MS + 1) * MS_CYCLES + 4;
  int unsigned rel_cnt;
  logic        rd_dur_q;
  logic        wr_mask;
  logic        rd_flag;

  assign wr_mask = take & wb_we_i & (wb_adr_i == ADDR_MASK) & (wb_sel_i == 4'hF);
  assign rd_flag = take & ~wb_we_i & (wb_adr_i == ADDR_FLAG);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rel_cnt  <= 0;
      rd_dur_q <= 1'b0;
    end else begin
      rel_cnt  <= ((tx_disable_o & ~st_reg.tx_off) != '0) ? rel_cnt + 1 : 0;
      rd_dur_q <= take & ~wb_we_i & (wb_adr_i == ADDR_DUR);
    end
  end

  sequence s_stop;
    stop_det;
  endsequence

  sequence s_flag_read;
    rd_flag && (set_v == 32'h0000_0000);
  endsequence

  property p_onset_irq;
    @(posedge clk_sys) disable iff (!resetn)
      ((set_v & ~st_reg.mask) != 32'h0) && !wr_mask |=> irq_o;
  endproperty
  a_onset_irq: assert property (p_onset_irq)
    else $error("unmasked onset did not raise interrupt");

  property p_rxlos_flag;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(st_reg.rxl_s2[0]) |=> st_reg.flag[FLAG_RXLOS_LSB];
  endproperty
  a_rxlos_flag: assert property (p_rxlos_flag)
    else $error("rx loss flag not latched");

  property p_txfail_flag;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(tx_fault_in[0]) |-> ##[1:4] st_reg.flag[FLAG_TXF_LSB];
  endproperty
  a_txfail_flag: assert property (p_txfail_flag)
    else $error("tx failure flag not latched in time");

  property p_flag_holds;
    @(posedge clk_sys) disable iff (!resetn)
      $fell(st_reg.flag[FLAG_TXLOS_LSB + LANES - 1]) |-> $past(take && wb_adr_i == ADDR_FLAG);
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("flag dropped without a host clear");

  property p_read_clears;
    @(posedge clk_sys) disable iff (!resetn)
      s_flag_read |=> (st_reg.flag == 32'h0) && !irq_o;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("flag read did not clear and drop interrupt");

  property p_mask_drop;
    @(posedge clk_sys) disable iff (!resetn)
      wr_mask && ((st_reg.flag & ~wb_dat_i) == 32'h0) && (set_v == 32'h0) |=> !irq_o;
  endproperty
  a_mask_drop: assert property (p_mask_drop)
    else $error("masking did not drop interrupt");

  property p_unmask_raise;
    @(posedge clk_sys) disable iff (!resetn)
      wr_mask && (wb_dat_i == 32'h0) && (st_reg.flag != 32'h0) && !rd_flag |=> irq_o;
  endproperty
  a_unmask_raise: assert property (p_unmask_raise)
    else $error("unmasking a set flag did not raise interrupt");

  property p_txoff_stop;
    @(posedge clk_sys) disable iff (!resetn)
      s_stop |=> ((tx_disable_o & $past(new_tx_off)) == $past(new_tx_off));
  endproperty
  a_txoff_stop: assert property (p_txoff_stop)
    else $error("tx lane not off after stop");

  property p_txon_bound;
    @(posedge clk_sys) disable iff (!resetn)
      rel_cnt <= REL_MAX;
  endproperty
  a_txon_bound: assert property (p_txon_bound)
    else $error("tx lane not re-enabled in time");

  property p_rxoff_stop;
    @(posedge clk_sys) disable iff (!resetn)
      s_stop |=> ((rx_squelch_o & $past(st_reg.ctrl[CTRL_RXOFF_LSB +: LANES]))
                  == $past(st_reg.ctrl[CTRL_RXOFF_LSB +: LANES]));
  endproperty
  a_rxoff_stop: assert property (p_rxoff_stop)
    else $error("rx output not disabled after stop");

  property p_rxon_stop;
    @(posedge clk_sys) disable iff (!resetn)
      s_stop ##0 (st_reg.ctrl[CTRL_RXOFF_LSB +: LANES] == '0)
        ##0 st_reg.ctrl[CTRL_SQDIS_BIT] |=> ##1 (rx_squelch_o == '0) && (tx_squelch_o == '0);
  endproperty
  a_rxon_stop: assert property (p_rxon_stop)
    else $error("outputs not restored or squelch not stopped");

  property p_rx_squelch;
    @(posedge clk_sys) disable iff (!resetn)
      !st_next.sq_dis && st_reg.rxl_s2[0] |=> rx_squelch_o[0];
  endproperty
  a_rx_squelch: assert property (p_rx_squelch)
    else $error("rx not squelched on loss");

  property p_tx_squelch;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(tx_los_in[LANES-1]) && !st_reg.sq_dis ##1 !st_reg.sq_dis [*3]
        |=> tx_squelch_o[LANES-1];
  endproperty
  a_tx_squelch: assert property (p_tx_squelch)
    else $error("tx not squelched on loss");

  property p_adv_dur;
    @(posedge clk_sys) disable iff (!resetn)
      rd_dur_q |-> (wb_dat_o[DUR_OFF_LSB +: 8] <= 8'(TXDIS_FAST_MS))
                && (wb_dat_o[DUR_ON_LSB +: 8] <= 8'(TXEN_FAST_MS));
  endproperty
  a_adv_dur: assert property (p_adv_dur)
    else $error("advertised tx duration above limit");

  property p_tick;
    @(posedge clk_sys) disable iff (!resetn)
      tick |=> !tick && (st_reg.tick_cnt == '0);
  endproperty
  a_tick: assert property (p_tick)
    else $error("millisecond tick malformed");

endmodule : module_flag_interrupt_latency

// File: shared/module_flag_pkg.sv
// Constants for the module flag, interrupt and output latency block.
// Assumes a 125 MHz system clock and a classic Wishbone register bus.
package module_flag_pkg;
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
  // Deadlines in ms, except the deassert time in us and the two derived counts in cycles
  localparam int unsigned INT_ASSERT_MS   = 200;
  localparam int unsigned LOS_ASSERT_MS   = 100;
  localparam int unsigned LOS_FAST_MS     = 1;
  localparam int unsigned TXFAIL_MS       = 200;
  localparam int unsigned FLAG_MS         = 200;
  localparam int unsigned INT_DEASSERT_US = 500;
  localparam int unsigned MASK_MS         = 100;
  localparam int unsigned TXDIS_MS        = 100;
  localparam int unsigned TXDIS_FAST_MS   = 3;
  localparam int unsigned TXEN_MS         = 400;
  localparam int unsigned TXEN_FAST_MS    = 10;
  localparam int unsigned RXDIS_MS        = 100;
  localparam int unsigned SQDIS_MS        = 100;
  localparam int unsigned RXSQ_MS         = 15;
  localparam int unsigned TXSQ_MS         = 400;
  localparam int unsigned INT_DEASSERT_CYC = (CLK_HZ / 1_000_000) * INT_DEASSERT_US;
  localparam int unsigned RXSQ_CYC        = RXSQ_MS * MS_CYCLES;
  // Tx lane settle time after re-enable, in ms ticks
  localparam int unsigned TX_ON_MS        = 2;
  localparam logic [7:0]  ADV_TX_OFF_MS   = 8'h01;
  localparam logic [7:0]  ADV_TX_ON_MS    = 8'(TX_ON_MS + 1);
  // Register map, byte addresses
  localparam int unsigned ADR_W           = 8;
  localparam logic [7:0]  ADDR_FLAG       = 8'h00;
  localparam logic [7:0]  ADDR_MASK       = 8'h04;
  localparam logic [7:0]  ADDR_CTRL       = 8'h08;
  localparam logic [7:0]  ADDR_STATE      = 8'h0C;
  localparam logic [7:0]  ADDR_DUR        = 8'h10;
  // Field positions and register reset values
  localparam int unsigned FLAG_RXLOS_LSB  = 0;
  localparam int unsigned FLAG_TXF_LSB    = 8;
  localparam int unsigned FLAG_TXLOS_LSB  = 16;
  localparam int unsigned CTRL_TXOFF_LSB  = 0;
  localparam int unsigned CTRL_RXOFF_LSB  = 8;
  localparam int unsigned CTRL_SQDIS_BIT  = 16;
  localparam int unsigned STATE_TXDIS_LSB = 24;
  localparam int unsigned DUR_OFF_LSB     = 0;
  localparam int unsigned DUR_ON_LSB      = 8;
  localparam logic [31:0] MASK_RST        = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
endpackage : module_flag_pkg

// File: sim/link_host_model.sv
// Managing host on the far side of the link pins.
// Assumes pulled-up lines, so both pins idle high between frames.
module link_host_model (
  output logic scl, // Link clock pin
  output logic sda  // Link data pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic lclk;

  // Phase offset keeps the link edges 1 ns after a system clock rising edge, never on one
  initial begin
    lclk = 1'b0;
    scl  = 1'b1;
    sda  = 1'b1;
    #37;
    forever #40 lclk = ~lclk;
  end

  // Clock pin only toggles inside a frame
  task automatic send_frame(input logic [7:0] byte_v);
    @(posedge lclk);
    sda <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge lclk);
      scl <= 1'b0;
      sda <= byte_v[i];
      @(posedge lclk);
      scl <= 1'b1;
    end
    @(posedge lclk);
    scl <= 1'b0;
    sda <= 1'b0;
    @(posedge lclk);
    scl <= 1'b1;
    @(posedge lclk);
    sda <= 1'b1; // Data rises with clock high
  endtask : send_frame
endmodule : link_host_model

// File: sim/module_flag_interrupt_latency_tb_top.sv
// Self-checking bench for flag, interrupt, output disable and squelch timing.
// Assumes the link host model beside it and a 1 ms tick shortened to MSC cycles.
module module_flag_interrupt_latency_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import module_flag_pkg::*;

  localparam int MSC = 10; // Cycles per ms tick in simulation
  typedef struct {logic [1:0] src; int lane; int lim_ms; logic [31:0] exp;} row_s;

  logic        clk_sys, resetn, cyc, stb, we, ack, irq, scl_in, sda_in;
  logic [7:0]  adr;
  logic [3:0]  sel, rx_los, tx_fault, tx_los, tx_dis, rx_sq, tx_sq;
  logic [31:0] dat_w, dat_r, rd_q;
  int          err_count, n_compared;
  row_s        rows[6];

  module_flag_interrupt_latency #(.LANES(4), .MS_CYCLES(MSC)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .scl_in(scl_in), .sda_in(sda_in), .rx_los_in(rx_los), .tx_fault_in(tx_fault),
    .tx_los_in(tx_los), .irq_o(irq), .tx_disable_o(tx_dis), .rx_squelch_o(rx_sq),
    .tx_squelch_o(tx_sq));

  link_host_model model_u (.scl(scl_in), .sda(sda_in));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task stop_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Entered just after a rising edge; holds the request until ack is seen
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    // Ack and read data are taken at the rising edge that sees ack high
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd_q = dat_r;
    chk({31'h0, ack}, 32'h1, "bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_sys);
  endtask : wb

  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    chk(rd_q, exp, what);
  endtask : rd

  function automatic logic pick(input int k, input int b);
    case (k)
      0: return irq;
      1: return tx_dis[b];
      2: return rx_sq[b];
      default: return tx_sq[b];
    endcase
  endfunction : pick

  // Bounded wait for an output level, then one compare
  task wait_on(input int k, input int b, input logic lvl, input int lim, input string what);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pick(k, b) !== lvl && n < lim);
    chk({31'h0, pick(k, b)}, {31'h0, lvl}, what);
    @(posedge clk_sys);
  endtask : wait_on

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    stop_test();
  end

  initial begin
    {resetn, cyc, stb, we, adr, dat_w, rx_los, tx_fault, tx_los} = '0;
    sel        = 4'hF;
    err_count  = 0;
    n_compared = 0;
    rows = '{'{2'd0, 0, LOS_FAST_MS, 32'h0000_0001}, '{2'd0, 3, LOS_FAST_MS, 32'h0000_0008},
             '{2'd1, 0, TXFAIL_MS, 32'h0000_0100}, '{2'd1, 2, TXFAIL_MS, 32'h0000_0400},
             '{2'd2, 1, FLAG_MS, 32'h0002_0000}, '{2'd2, 3, INT_ASSERT_MS, 32'h0008_0000}};
    repeat (12) @(posedge clk_sys);
    chk({27'h0, irq, tx_dis}, 32'h0, "outputs in reset");
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(ADDR_MASK, MASK_RST, "mask reset");
    rd(ADDR_CTRL, CTRL_RST, "control reset");
    rd(ADDR_DUR, {16'h0, ADV_TX_ON_MS, ADV_TX_OFF_MS}, "advertised times");
    chk({31'h0, rd_q[7:0] <= TXDIS_FAST_MS && rd_q[15:8] <= TXEN_FAST_MS},
        32'h1, "bounds");
    wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0, "unmapped read");
    foreach (rows[i]) begin
      case (rows[i].src)
        2'd0: rx_los[rows[i].lane] <= 1'b1;
        2'd1: tx_fault[rows[i].lane] <= 1'b1;
        default: tx_los[rows[i].lane] <= 1'b1;
      endcase
      wait_on(0, 0, 1'b1, rows[i].lim_ms * MSC, "irq on onset");
      {rx_los, tx_fault, tx_los} <= '0;
      rd(ADDR_FLAG, rows[i].exp, "flag latched");
      wait_on(0, 0, 1'b0, INT_DEASSERT_US * MSC / 1000, "irq after read");
      rd(ADDR_FLAG, 32'h0, "flag cleared by read");
    end
    // Two sources at once: masking one must not drop the request
    rx_los[1]   <= 1'b1;
    tx_fault[1] <= 1'b1;
    wait_on(0, 0, 1'b1, LOS_FAST_MS * MSC, "irq two sources");
    {rx_los, tx_fault} <= '0;
    wb(1'b1, ADDR_MASK, 32'h0000_0002);
    wait_on(0, 0, 1'b1, 1, "irq held by other flag");
    wb(1'b1, ADDR_MASK, 32'h0000_0202);
    wait_on(0, 0, 1'b0, MASK_MS * MSC, "irq masked");
    wb(1'b1, ADDR_MASK, 32'h0000_0002);
    wait_on(0, 0, 1'b1, MASK_MS * MSC, "irq unmasked");
    wb(1'b1, ADDR_FLAG, 32'h0000_0200);
    wait_on(0, 0, 1'b0, INT_DEASSERT_US * MSC / 1000, "irq after clear");
    wb(1'b1, ADDR_MASK, 32'h0);
    rd(ADDR_FLAG, 32'h0000_0002, "masked flag kept");
    // Control waits for the link stop
    wb(1'b1, ADDR_CTRL, 32'h0000_0204);
    repeat (6) @(posedge clk_sys);
    chk({24'h0, rx_sq, tx_dis}, 32'h0, "held until stop");
    rd(ADDR_CTRL, 32'h0000_0204, "pending readback");
    model_u.send_frame(8'hA0);
    wait_on(1, 2, 1'b1, TXDIS_FAST_MS * MSC, "tx lane off");
    wait_on(2, 1, 1'b1, RXDIS_MS * MSC, "rx output off");
    rd(ADDR_STATE, 32'h0400_0204, "applied state");
    wb(1'b1, ADDR_CTRL, 32'h0);
    model_u.send_frame(8'h5A);
    wait_on(2, 1, 1'b0, RXDIS_MS * MSC, "rx output on");
    wait_on(1, 2, 1'b0, (TX_ON_MS + 1) * MSC, "tx lane on");
    // Auto squelch off and back on while loss persists
    rx_los[0] <= 1'b1;
    tx_los[3] <= 1'b1;
    wait_on(2, 0, 1'b1, RXSQ_MS * MSC, "rx squelch");
    wait_on(3, 3, 1'b1, TXSQ_MS * MSC, "tx squelch");
    wb(1'b1, ADDR_CTRL, 32'h0001_0000);
    model_u.send_frame(8'hA0);
    wait_on(2, 0, 1'b0, SQDIS_MS * MSC, "rx squelch stopped");
    wait_on(3, 3, 1'b0, SQDIS_MS * MSC, "tx squelch stopped");
    wb(1'b1, ADDR_CTRL, 32'h0);
    model_u.send_frame(8'hA0);
    wait_on(2, 0, 1'b1, SQDIS_MS * MSC, "rx squelch resumed");
    wait_on(3, 3, 1'b1, SQDIS_MS * MSC, "tx squelch resumed");
    {rx_los, tx_los} <= '0;
    rd(ADDR_FLAG, 32'h0008_0001, "loss flags");
    // Mid-run reset must return outputs and mask to their reset values
    wb(1'b1, ADDR_MASK, 32'h0000_00FF);
    resetn <= 1'b0;
    @(posedge clk_sys);
    chk({19'h0, irq, tx_dis, rx_sq, tx_sq}, 32'h0, "outputs in mid-run reset");
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(ADDR_MASK, MASK_RST, "mask after mid-run reset");
    rd(ADDR_FLAG, 32'h0, "no flag after mid-run reset");
    stop_test();
  end
endmodule : module_flag_interrupt_latency_tb_top
